// file: design/trd_defs.svh
`ifndef TRD_DEFS_SVH
`define TRD_DEFS_SVH

// ==========================================
// ternary symbol codes, two-bit signed, and the data kind code
`define TRD_SYM_POS    2'h1
`define TRD_SYM_NEG    2'h3
`define TRD_SYM_ZERO   2'h0
`define TRD_KIND_DATA  2'h2

// ==========================================
// framing and synchroniser width
`define TRD_GRP_SYMS   6
`define TRD_PAIRS      3
`define TRD_PRE_SYMS   2'h2
`define TRD_SFD_LO     4'h5
`define TRD_SFD_HI     4'hd
`define TRD_SYNC_W     18
`define TRD_TERM_NEXT  4
`define TRD_TERM_THIRD 2

// ==========================================
// timing counts
`define TRD_RELATCH_SYMS 20
`define TRD_SETTLE_CYC   16

// ==========================================
// register port map
`define TRD_REG_CTRL   4'h0
`define TRD_REG_STAT   4'h4
`define TRD_REG_ERRS   4'h8
`define TRD_CTRL_LOOP  0
`define TRD_CTRL_PDN   1

`endif

// file: design/trd_pkg.sv
package trd_pkg;

  typedef logic [1:0] trd_sym_t;

  typedef enum logic [2:0] {
    idle_wait_state,
    collect_state,
    fourth_symbol_state,
    fifth_symbol_state,
    decode_state,
    term_state
  } trd_state_t;

  typedef enum logic [2:0] {
    em_none,
    em_sfd_lo,
    em_sfd_hi,
    em_data_lo,
    em_data_hi
  } trd_emit_t;

endpackage : trd_pkg

// file: design/trd_pair_hist.sv
`timescale 1ns/1ps
`default_nettype none
`include "trd_defs.svh"

module trd_pair_hist (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rst_b,
  // symbol feed
  input  wire logic                   shift_i,
  input  wire trd_pkg::trd_sym_t      sym_i,
  // running weight control
  input  wire logic                   clear_i,
  input  wire logic                   toggle_i,
  // state
  output logic [2*`TRD_GRP_SYMS-1:0]  group_o,
  output logic                        weight_bit_o
);

  // newest symbol sits in the low bits, oldest in the top
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      group_o <= '0;
    end else if (shift_i) begin
      group_o <= {group_o[2*`TRD_GRP_SYMS-3:0], sym_i};
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || clear_i) begin
      weight_bit_o <= 1'b0;
    end else if (toggle_i) begin
      weight_bit_o <= ~weight_bit_o;
    end
  end

endmodule : trd_pair_hist
`default_nettype wire

// file: design/trd_rx_pcs.sv
`timescale 1ns/1ps
`default_nettype none
`include "trd_defs.svh"

module trd_rx_pcs #(
  parameter int RELATCH_SYMS = `TRD_RELATCH_SYMS,
  parameter int SETTLE_CYC   = `TRD_SETTLE_CYC
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_b,
  // symbol layer
  input  wire logic        sym_clk,
  input  wire logic [1:0]  rx_kind,
  input  wire logic [1:0]  rx_sym_only,
  input  wire logic [1:0]  rx_sym_bidir_b,
  input  wire logic [1:0]  rx_sym_bidir_a,
  input  wire logic        line_act,
  input  wire logic        pma_err,
  input  wire logic        link_ok,
  input  wire logic        tx_sym_active,
  // mii
  input  wire logic        tx_en,
  input  wire logic [3:0]  txd,
  output logic             rx_clk,
  output logic             rx_dv,
  output logic             rx_er,
  output logic [3:0]       rxd,
  output logic             crs,
  output logic             col,
  // transmit gate
  output logic             tx_sym_allow,
  // code table
  output logic [11:0]      lut_group,
  input  wire logic [7:0]  lut_octet,
  input  wire logic        lut_hit,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata
);

  if (RELATCH_SYMS < 1 || RELATCH_SYMS > 255 || SETTLE_CYC < 1 || SETTLE_CYC > 255) begin : g_chk
    $error("trd_rx_pcs: count parameter out of range 1..255");
  end

  // ==========================================
  // input synchronisers and symbol strobes
  logic [`TRD_SYNC_W-1:0] sync1_r;
  logic [`TRD_SYNC_W-1:0] sync2_r;
  logic                   s_clk, s_act, s_perr, s_link, s_txen, s_txact;
  logic [3:0]             s_txd;
  logic [1:0]             s_kind;
  trd_pkg::trd_sym_t      sym_in [`TRD_PAIRS];
  logic                   sclk_d_r, p0, p1_r, p2_r;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {sym_clk, line_act, pma_err, link_ok, tx_en, tx_sym_active,
                  txd, rx_kind, rx_sym_bidir_a, rx_sym_bidir_b, rx_sym_only};
      sync2_r <= sync1_r;
    end
  end

  assign {s_clk, s_act, s_perr, s_link, s_txen, s_txact, s_txd, s_kind,
          sym_in[2], sym_in[1], sym_in[0]} = sync2_r;

  // symbols are assumed settled well before the symbol clock rises
  assign p0 = s_clk & ~sclk_d_r;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      sclk_d_r <= 1'b0;
      p1_r     <= 1'b0;
      p2_r     <= 1'b0;
      rx_clk   <= 1'b0;
    end else begin
      sclk_d_r <= s_clk;
      p1_r     <= p0;
      p2_r     <= p1_r;
      rx_clk   <= s_clk;
    end
  end

  // ==========================================
  // per-pair history and running weight
  trd_pkg::trd_state_t    state_r;
  trd_pkg::trd_emit_t     emit_r;
  logic [11:0]            grp [`TRD_PAIRS];
  logic [`TRD_PAIRS-1:0]  rw;
  logic [`TRD_PAIRS-1:0]  rw_tog;
  logic [1:0]             pair_r;
  logic                   dec_p2, upd_r, bad_group_flag;

  for (genvar i = 0; i < `TRD_PAIRS; i++) begin : g_pair
    trd_pair_hist u_hist (
      .core_clk     (core_clk),
      .rst_b        (rst_b),
      .shift_i      (p0),
      .sym_i        (sym_in[i]),
      .clear_i      (state_r == trd_pkg::idle_wait_state),
      .toggle_i     (rw_tog[i]),
      .group_o      (grp[i]),
      .weight_bit_o (rw[i])
    );
    assign rw_tog[i] = dec_p2 && upd_r && !bad_group_flag && pair_r == 2'(i);
  end

  // ==========================================
  // receive sequence
  logic [1:0] cnt_r;
  logic       slot_r, loop_r, frame_lost, eop_hit_r;

  assign frame_lost = !s_act && state_r != trd_pkg::idle_wait_state
                      && state_r != trd_pkg::term_state;

  always_ff @(posedge core_clk) begin
    if (!rst_b || frame_lost) begin
      state_r <= trd_pkg::idle_wait_state;
      emit_r  <= trd_pkg::em_none;
      cnt_r   <= '0;
      slot_r  <= 1'b0;
    end else if (p2_r && eop_hit_r) begin
      state_r <= trd_pkg::term_state;
    end else if (p0) begin
      emit_r <= trd_pkg::em_none;
      case (state_r)
        trd_pkg::idle_wait_state: begin
          if (s_kind == `TRD_KIND_DATA && !loop_r) begin
            state_r <= trd_pkg::collect_state;
            cnt_r   <= 2'h1;
          end
        end
        trd_pkg::collect_state: begin
          if (cnt_r == `TRD_PRE_SYMS) begin
            state_r <= trd_pkg::fourth_symbol_state;
          end else begin
            cnt_r <= cnt_r + 2'h1;
          end
        end
        trd_pkg::fourth_symbol_state: begin
          emit_r  <= trd_pkg::em_sfd_lo;
          state_r <= trd_pkg::fifth_symbol_state;
        end
        trd_pkg::fifth_symbol_state: begin
          emit_r  <= trd_pkg::em_sfd_hi;
          state_r <= trd_pkg::decode_state;
          slot_r  <= 1'b1;
        end
        trd_pkg::decode_state: begin
          emit_r <= slot_r ? trd_pkg::em_data_lo : trd_pkg::em_data_hi;
          slot_r <= ~slot_r;
        end
        trd_pkg::term_state: begin
          if (s_kind != `TRD_KIND_DATA) begin
            state_r <= trd_pkg::idle_wait_state;
          end
        end
        default: state_r <= trd_pkg::idle_wait_state;
      endcase
    end
  end

  // ==========================================
  // group checks and table lookup
  function automatic logic signed [3:0] grp_weight(input logic [11:0] g);
    logic signed [3:0] w;
    w = '0;
    for (int k = 0; k < `TRD_GRP_SYMS; k++) begin
      w = w + 4'(signed'(g[2*k +: 2]));
    end
    return w;
  endfunction : grp_weight

  function automatic logic all_eq(input logic [11:0] g, input logic [1:0] s, input int n);
    logic ok;
    ok = 1'b1;
    for (int k = 0; k < n; k++) begin
      ok = ok & (g[2*k +: 2] == s);
    end
    return ok;
  endfunction : all_eq

  function automatic logic [11:0] grp_negate(input logic [11:0] g);
    logic [11:0] r;
    r = '0;
    for (int k = 0; k < `TRD_GRP_SYMS; k++) begin
      r[2*k +: 2] = 2'(-signed'(g[2*k +: 2]));
    end
    return r;
  endfunction : grp_negate

  logic [1:0]        nx, th;
  logic [11:0]       cur_g;
  logic signed [3:0] cur_w;
  logic              first_terminator_group, conform, dec_p1;
  logic              weight_violation_flag_r, bad_terminator_flag_r;

  assign nx      = (pair_r == 2'h2) ? 2'h0 : pair_r + 2'h1;
  assign th      = (nx == 2'h2) ? 2'h0 : nx + 2'h1;
  assign cur_g   = grp[pair_r];
  assign cur_w   = grp_weight(cur_g);
  assign first_terminator_group = all_eq(cur_g, `TRD_SYM_POS, `TRD_GRP_SYMS)
                                | all_eq(cur_g, `TRD_SYM_NEG, `TRD_GRP_SYMS);
  // terminators are sent negated when the pair's weight bit is clear
  assign conform = all_eq(grp[nx], rw[nx] ? `TRD_SYM_POS : `TRD_SYM_NEG, `TRD_TERM_NEXT)
                 & all_eq(grp[th], rw[th] ? `TRD_SYM_POS : `TRD_SYM_NEG, `TRD_TERM_THIRD);
  assign dec_p1  = p1_r && emit_r == trd_pkg::em_data_lo && state_r == trd_pkg::decode_state;
  assign dec_p2  = p2_r && emit_r == trd_pkg::em_data_lo && state_r == trd_pkg::decode_state;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      lut_group <= '0;
    end else if (dec_p1 && !first_terminator_group) begin
      lut_group <= (cur_w == -4'sd1 && rw[pair_r]) ? grp_negate(cur_g) : cur_g;
    end
  end

  // flags live for the single cycle after the check
  always_ff @(posedge core_clk) begin
    if (!rst_b || !dec_p1) begin
      weight_violation_flag_r <= 1'b0;
      bad_terminator_flag_r   <= 1'b0;
      eop_hit_r               <= 1'b0;
      upd_r                   <= 1'b0;
    end else if (first_terminator_group) begin
      eop_hit_r             <= 1'b1;
      bad_terminator_flag_r <= !conform;
    end else if (cur_w > 4'sd1 || cur_w < -4'sd1) begin
      weight_violation_flag_r <= 1'b1;
    end else if (cur_w == 4'sd1) begin
      weight_violation_flag_r <= rw[pair_r];
      upd_r                   <= !rw[pair_r];
    end else if (cur_w == -4'sd1) begin
      weight_violation_flag_r <= !rw[pair_r];
      upd_r                   <= rw[pair_r];
    end
  end

  logic [7:0] dec_octet;
  logic       dec_err;

  assign bad_group_flag = dec_p2 && !eop_hit_r && !weight_violation_flag_r && !lut_hit;
  assign dec_err        = weight_violation_flag_r | bad_group_flag;
  assign dec_octet      = dec_err ? 8'h00 : lut_octet;

  // ==========================================
  // holding registers and terminator state
  logic [7:0] hold_r [`TRD_PAIRS];
  logic       herr_r [`TRD_PAIRS];
  logic [1:0] out_sel_r;
  logic       terminator_seen_r;

  always_ff @(posedge core_clk) begin
    if (!rst_b || state_r == trd_pkg::idle_wait_state) begin
      pair_r            <= '0;
      out_sel_r         <= '0;
      terminator_seen_r <= 1'b0;
    end else if (dec_p2 && eop_hit_r) begin
      terminator_seen_r <= 1'b1;
    end else if (dec_p2) begin
      hold_r[pair_r] <= dec_octet;
      herr_r[pair_r] <= dec_err;
      out_sel_r      <= pair_r;
      pair_r         <= nx;
    end
  end

  // ==========================================
  // mii receive stream, one symbol of delay
  logic       ent_dv, ent_er;
  logic [3:0] ent_nib;
  logic       pipe_dv_r, pipe_er_r;
  logic [3:0] pipe_nib_r;

  always_comb begin
    ent_dv  = 1'b1;
    ent_er  = s_perr;
    ent_nib = '0;
    if (loop_r) begin
      ent_dv  = s_txen;
      ent_er  = 1'b0;
      ent_nib = s_txen ? s_txd : 4'h0;
    end else begin
      case (emit_r)
        trd_pkg::em_sfd_lo:  ent_nib = `TRD_SFD_LO;
        trd_pkg::em_sfd_hi:  ent_nib = `TRD_SFD_HI;
        trd_pkg::em_data_lo: begin
          ent_dv  = !eop_hit_r;
          ent_er  = (s_perr | dec_err) & !eop_hit_r;
          ent_nib = eop_hit_r ? 4'h0 : dec_octet[3:0];
        end
        trd_pkg::em_data_hi: begin
          ent_er  = s_perr | herr_r[out_sel_r];
          ent_nib = hold_r[out_sel_r][7:4];
        end
        default: begin
          ent_dv = 1'b0;
          ent_er = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pipe_dv_r  <= 1'b0;
      pipe_er_r  <= 1'b0;
      pipe_nib_r <= '0;
      rx_dv      <= 1'b0;
      rx_er      <= 1'b0;
      rxd        <= '0;
    end else if (frame_lost) begin
      pipe_dv_r  <= 1'b0;
      pipe_er_r  <= 1'b0;
      pipe_nib_r <= '0;
      rx_dv      <= 1'b0;
      rx_er      <= 1'b1;
      rxd        <= '0;
    end else if (p2_r) begin
      rx_dv      <= pipe_dv_r;
      rx_er      <= pipe_er_r | bad_terminator_flag_r;
      rxd        <= pipe_dv_r ? pipe_nib_r : 4'h0;
      pipe_dv_r  <= ent_dv;
      pipe_er_r  <= ent_er;
      pipe_nib_r <= ent_dv ? ent_nib : 4'h0;
    end
  end

  // ==========================================
  // carrier sense and collision
  logic       act_d_r, latch_r, armed_r;
  logic [7:0] relatch_r;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      act_d_r   <= 1'b0;
      latch_r   <= 1'b0;
      armed_r   <= 1'b0;
      relatch_r <= '0;
    end else begin
      act_d_r <= s_act;
      if (s_act && !act_d_r) begin
        latch_r <= 1'b1;
      end else if (!s_act && act_d_r) begin
        latch_r <= 1'b0;
        armed_r <= 1'b0;
      end else if (dec_p2 && eop_hit_r && !bad_terminator_flag_r) begin
        latch_r   <= 1'b0;
        armed_r   <= 1'b1;
        relatch_r <= '0;
      end else if (armed_r && p0) begin
        if (relatch_r == 8'(RELATCH_SYMS - 1)) begin
          latch_r <= 1'b1;
          armed_r <= 1'b0;
        end else begin
          relatch_r <= relatch_r + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      crs <= 1'b0;
      col <= 1'b0;
    end else begin
      crs <= s_link & (latch_r | s_txen);
      col <= s_link & s_txact & s_act;
    end
  end

  // ==========================================
  // control, power gate, registers
  logic        pdn_r;
  logic [7:0]  settle_r;
  logic [15:0] errs_r;
  logic        err_evt;

  assign err_evt = dec_err | bad_terminator_flag_r;

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      loop_r <= 1'b0;
      pdn_r  <= 1'b0;
    end else if (reg_wr && reg_addr == `TRD_REG_CTRL) begin
      loop_r <= reg_wdata[`TRD_CTRL_LOOP];
      pdn_r  <= reg_wdata[`TRD_CTRL_PDN];
    end
  end

  // settle time covers both power-up and release from power-down
  always_ff @(posedge core_clk) begin
    if (!rst_b || pdn_r) begin
      settle_r     <= 8'(SETTLE_CYC);
      tx_sym_allow <= 1'b0;
    end else begin
      if (settle_r != 8'h00) begin
        settle_r <= settle_r - 8'h01;
      end
      tx_sym_allow <= (settle_r == 8'h00);
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      errs_r <= '0;
    end else if (reg_wr && reg_addr == `TRD_REG_ERRS) begin
      errs_r <= err_evt ? 16'h0001 : 16'h0000;
    end else if (err_evt && errs_r != 16'hffff) begin
      errs_r <= errs_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_b || !reg_rd) begin
      reg_rdata <= '0;
    end else if (reg_addr == `TRD_REG_CTRL) begin
      reg_rdata <= 32'({pdn_r, loop_r});
    end else if (reg_addr == `TRD_REG_STAT) begin
      reg_rdata <= 32'({state_r != trd_pkg::idle_wait_state, latch_r, terminator_seen_r, rw});
    end else if (reg_addr == `TRD_REG_ERRS) begin
      reg_rdata <= 32'(errs_r);
    end else begin
      reg_rdata <= '0;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_rxd_zero;
    !rx_dv |-> rxd == 4'h0;
  endproperty
  a_rxd_zero: assert property (p_rxd_zero) else $error("rxd not zero while rx_dv low");

  property p_term_drop;
    (p2_r && eop_hit_r && !loop_r) |=> !pipe_dv_r;
  endproperty
  a_term_drop: assert property (p_term_drop) else $error("terminator nibble marked valid");

  property p_viol_zero;
    (dec_p2 && weight_violation_flag_r) |-> dec_octet == 8'h00 && !bad_group_flag;
  endproperty
  a_viol_zero: assert property (p_viol_zero) else $error("violation octet not zero");

  property p_bit_kept;
    (dec_p2 && dec_err) |=> $stable(rw);
  endproperty
  a_bit_kept: assert property (p_bit_kept) else $error("weight bit moved on error");

  property p_idle_clear;
    (state_r == trd_pkg::idle_wait_state) ##1 (state_r == trd_pkg::idle_wait_state) |-> rw == '0;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("weight bits not cleared in idle");

  property p_quiet;
    !p2_r |-> !weight_violation_flag_r && !bad_terminator_flag_r && !bad_group_flag;
  endproperty
  a_quiet: assert property (p_quiet) else $error("error flag outside a check");

  property p_bad_term;
    (p2_r && bad_terminator_flag_r && !frame_lost) |=> rx_er;
  endproperty
  a_bad_term: assert property (p_bad_term) else $error("bad terminator not shown");

  property p_trunc;
    frame_lost |=> rx_er && !rx_dv ##1 state_r == trd_pkg::idle_wait_state;
  endproperty
  a_trunc: assert property (p_trunc) else $error("lost frame not ended");

  property p_pdn;
    pdn_r |=> !tx_sym_allow;
  endproperty
  a_pdn: assert property (p_pdn) else $error("transmit allowed in power-down");

  property p_col;
    !s_link |=> !col && !crs;
  endproperty
  a_col: assert property (p_col) else $error("carrier or collision without link");

  property p_sfd;
    (p2_r && emit_r == trd_pkg::em_sfd_lo && !loop_r && !frame_lost) |=> pipe_dv_r && pipe_nib_r == `TRD_SFD_LO;
  endproperty
  a_sfd: assert property (p_sfd) else $error("sfd low nibble wrong");

endmodule : trd_rx_pcs
`default_nettype wire

// file: testbench/trd_pma_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "trd_defs.svh"

module trd_pma_model (
  // symbol layer
  output logic             sym_clk,
  output logic [1:0]       rx_kind,
  output logic [1:0]       rx_sym_only,
  output logic [1:0]       rx_sym_bidir_b,
  output logic [1:0]       rx_sym_bidir_a,
  // code table
  input  wire logic [11:0] lut_group,
  output logic [7:0]       lut_octet,
  output logic             lut_hit
);
  // ==========================================
  // link side
  initial begin
    sym_clk = 1'b0;
    idle();
  end

  // link clock stands still between frames; every change falls between core clock edges
  // the caller waits 10 ns after each symbol to keep the 800 ns period
  task automatic send(input logic [1:0] kind, input logic [1:0] s);
    #10;
    rx_kind = kind;
    rx_sym_only = s;
    rx_sym_bidir_b = `TRD_SYM_ZERO;
    rx_sym_bidir_a = `TRD_SYM_ZERO;
    #400;
    sym_clk = 1'b1;
    #380;
    sym_clk = 1'b0;
  endtask : send

  // released lines carry a code that is no ternary value at all
  task automatic idle();
    rx_kind = 2'h0;
    rx_sym_only = 2'h2;
    rx_sym_bidir_b = 2'h2;
    rx_sym_bidir_a = 2'h2;
  endtask : idle

  // ==========================================
  // reduced code table: two entries, all else missing
  always_comb begin
    lut_hit = 1'b1;
    case (lut_group)
      12'h707: lut_octet = 8'ha3;
      12'h400: lut_octet = 8'h4c;
      default: begin
        lut_octet = 8'h00;
        lut_hit = 1'b0;
      end
    endcase
  end
endmodule : trd_pma_model
`default_nettype wire

// file: testbench/ternary_receive_decoder_pcs_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "trd_defs.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin error_cnt++; \
  $display("[ERR] %s expected %h seen %h", nm, exp, got); end end

module ternary_receive_decoder_pcs_bench;
  typedef struct packed {
    logic [11:0] grp;
    logic [7:0]  oct;
    logic        er;
    logic        perr;
    logic        wnz;
  } trd_frame_row_t;
  typedef struct packed {
    logic [3:0] in;
    logic       crs;
    logic       col;
  } trd_cs_row_t;

  logic        core_clk, rst_b, sym_clk, line_act, pma_err, link_ok, tx_sym_active, tx_en;
  logic        rx_clk, rx_dv, rx_er, crs, col, tx_sym_allow, lut_hit, reg_wr, reg_rd;
  logic [1:0]  rx_kind, rx_sym_only, rx_sym_bidir_b, rx_sym_bidir_a;
  logic [3:0]  txd, rxd, reg_addr;
  logic [7:0]  lut_octet;
  logic [11:0] lut_group;
  logic [31:0] reg_wdata, reg_rdata, v;
  int          error_cnt, comparisons, cycles;

  // ordinary frames: group on the first pair, octet, error, medium error, weight bit set
  // the all-plus group ends the frame with a badly framed terminator
  trd_frame_row_t frows [7] = '{
    '{12'h707, 8'ha3, 1'b0, 1'b0, 1'b0},
    '{12'h400, 8'h4c, 1'b0, 1'b0, 1'b1},
    '{12'h000, 8'h00, 1'b1, 1'b0, 1'b0},
    '{12'h500, 8'h00, 1'b1, 1'b0, 1'b0},
    '{12'hc00, 8'h00, 1'b1, 1'b0, 1'b0},
    '{12'h707, 8'ha3, 1'b1, 1'b1, 1'b0},
    '{12'h555, 8'h00, 1'b0, 1'b0, 1'b0}};
  // {link, tx enable, sending, line activity}
  trd_cs_row_t crows [5] = '{'{4'hc, 1'b1, 1'b0}, '{4'hb, 1'b1, 1'b1}, '{4'h7, 1'b0, 1'b0},
                             '{4'ha, 1'b0, 1'b0}, '{4'h8, 1'b0, 1'b0}};

  trd_rx_pcs #(.RELATCH_SYMS(2), .SETTLE_CYC(4)) i_trd_rx_pcs (
    .core_clk(core_clk), .rst_b(rst_b), .sym_clk(sym_clk), .rx_kind(rx_kind),
    .rx_sym_only(rx_sym_only), .rx_sym_bidir_b(rx_sym_bidir_b), .rx_sym_bidir_a(rx_sym_bidir_a),
    .line_act(line_act), .pma_err(pma_err), .link_ok(link_ok), .tx_sym_active(tx_sym_active),
    .tx_en(tx_en), .txd(txd), .rx_clk(rx_clk), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd),
    .crs(crs), .col(col), .tx_sym_allow(tx_sym_allow), .lut_group(lut_group),
    .lut_octet(lut_octet), .lut_hit(lut_hit), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  trd_pma_model i_trd_pma_model (
    .sym_clk(sym_clk), .rx_kind(rx_kind), .rx_sym_only(rx_sym_only),
    .rx_sym_bidir_b(rx_sym_bidir_b), .rx_sym_bidir_a(rx_sym_bidir_a),
    .lut_group(lut_group), .lut_octet(lut_octet), .lut_hit(lut_hit));

  // ==========================================
  // clock, timeout, verdict
  always #50 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // ==========================================
  // register port
  task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : reg_read

  // ==========================================
  // one frame, then loss of line activity, which cuts short every frame but the one with the terminator
  task automatic run_frame(input trd_frame_row_t r);
    logic [1:0] s;
    logic [31:0] st;
    logic term;
    term = (r.grp == 12'h555);
    @(posedge core_clk);
    line_act <= 1'b1;
    pma_err <= r.perr;
    // each nibble shows on the mii two symbols after the one that decided it
    for (int t = 1; t <= 9; t++) begin
      s = (t <= 6) ? r.grp[13-2*t -: 2] : `TRD_SYM_ZERO;
      i_trd_pma_model.send(`TRD_KIND_DATA, s);
      if (t == 6) `CHK("sfd_lo", {1'b1, `TRD_SFD_LO}, {rx_dv, rxd})
      if (t == 7) `CHK("sfd_hi", {1'b1, r.perr | term, `TRD_SFD_HI}, {rx_dv, rx_er, rxd})
      if (t == 8) `CHK("oct_lo", {!term, r.er, r.oct[3:0]}, {rx_dv, rx_er, rxd})
      if (t == 9) `CHK("oct_hi", {!term, r.er, r.oct[7:4]}, {rx_dv, rx_er, rxd})
      #10;
    end
    reg_read(`TRD_REG_STAT, st);
    `CHK("weight", r.wnz, |st[2:0])
    @(posedge core_clk);
    line_act <= 1'b0;
    pma_err <= 1'b0;
    repeat (6) @(posedge core_clk);
    #1;
    `CHK("trunc", {1'b0, !term, 4'h0}, {rx_dv, rx_er, rxd})
    i_trd_pma_model.idle();
    repeat (30) @(posedge core_clk);
  endtask : run_frame

  // ==========================================
  // main sequence
  initial begin
    {core_clk, rst_b, line_act, pma_err, tx_sym_active, tx_en, reg_wr, reg_rd} = '0;
    link_ok = 1'b1;
    txd = 4'h0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    repeat (12) @(posedge core_clk);
    #1;
    `CHK("rst_out", 6'h00, {rx_dv, rx_er, crs, col, rx_clk, tx_sym_allow})
    @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    #1;
    `CHK("settle", 1'b0, tx_sym_allow)
    repeat (12) @(posedge core_clk);
    #1;
    `CHK("tx_gate_on", 1'b1, tx_sym_allow)
    $display("test reset done");
    foreach (frows[i]) run_frame(frows[i]);
    $display("test frames done");
    foreach (crows[i]) begin
      @(posedge core_clk);
      {link_ok, tx_en, tx_sym_active, line_act} <= crows[i].in;
      repeat (8) @(posedge core_clk);
      #1;
      `CHK("crs_col", {crows[i].crs, crows[i].col}, {crs, col})
    end
    @(posedge core_clk);
    {link_ok, tx_en, tx_sym_active, line_act} <= 4'h8;
    $display("test carrier done");
    reg_write(`TRD_REG_CTRL, 32'h2);
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("tx_gate_pdn", 1'b0, tx_sym_allow)
    reg_read(`TRD_REG_CTRL, v);
    `CHK("ctrl", 32'h2, v)
    reg_read(4'hc, v);
    `CHK("unmapped", 32'h0, v)
    reg_write(`TRD_REG_CTRL, 32'h0);
    #1;
    `CHK("tx_gate_leave", 1'b0, tx_sym_allow)
    repeat (10) @(posedge core_clk);
    #1;
    `CHK("tx_gate_back", 1'b1, tx_sym_allow)
    $display("test power done");
    reg_write(`TRD_REG_CTRL, 32'h1);
    @(posedge core_clk);
    tx_en <= 1'b1;
    txd <= 4'h9;
    // the receive stream only moves on symbol clock rises
    repeat (2) begin
      i_trd_pma_model.send(2'h0, `TRD_SYM_ZERO);
      #10;
    end
    i_trd_pma_model.send(2'h0, `TRD_SYM_ZERO);
    `CHK("loop", 5'h19, {rx_dv, rxd})
    @(posedge core_clk);
    tx_en <= 1'b0;
    reg_write(`TRD_REG_CTRL, 32'h0);
    $display("test loopback done");
    report_and_stop();
  end
endmodule : ternary_receive_decoder_pcs_bench
`undef CHK
`default_nettype wire
